// [core/roi_crop_pkg.sv]
package roi_crop_pkg;

    localparam int DIM_W   = 16;
    localparam int PIX_W   = 8;
    localparam int TAP_MAX = 10;
    localparam int LANE_W  = 4;
    localparam int EXPO_W  = 32;
    localparam int WB_AW   = 8;
    localparam int WB_DW   = 32;

    // clock rates, figures as printed
    localparam int SYS_CLK_HZ  = 100_000_000;
    localparam int LINK_CLK_HZ = 85_000_000;

    // register byte addresses
    localparam logic [WB_AW-1:0] ADR_ROI_COLS       = 8'h00;
    localparam logic [WB_AW-1:0] ADR_ROI_ROWS       = 8'h04;
    localparam logic [WB_AW-1:0] ADR_COL_START      = 8'h08;
    localparam logic [WB_AW-1:0] ADR_ROW_START      = 8'h0C;
    localparam logic [WB_AW-1:0] ADR_TAP_SEL        = 8'h10;
    localparam logic [WB_AW-1:0] ADR_EXPO_CYCLES    = 8'h14;
    localparam logic [WB_AW-1:0] ADR_STATUS         = 8'h18;
    localparam logic [WB_AW-1:0] ADR_SENSOR_COLS    = 8'h1C;
    localparam logic [WB_AW-1:0] ADR_SENSOR_ROWS    = 8'h20;
    localparam logic [WB_AW-1:0] ADR_IMG_COLS_LIMIT = 8'h24;
    localparam logic [WB_AW-1:0] ADR_IMG_ROWS_LIMIT = 8'h28;

    // status bits
    localparam int STAT_REJECT = 0;
    localparam int STAT_BUSY   = 1;

    // window geometry limits, in pixels
    localparam logic [DIM_W-1:0] COLS_ALIGN_MASK = 16'h000F;
    localparam logic [DIM_W-1:0] ROWS_ALIGN_MASK = 16'h0003;
    localparam logic [DIM_W-1:0] COLS_MIN        = 16'h0040;
    localparam logic [DIM_W-1:0] ROWS_MIN        = 16'h0004;
    localparam logic [DIM_W-1:0] ORIGIN          = 16'h0000;

    localparam logic [EXPO_W-1:0] EXPO_RESET = 32'h0000_0001;

    typedef enum logic [1:0] {
        TAP_2  = 2'b00,
        TAP_4  = 2'b01,
        TAP_8  = 2'b10,
        TAP_10 = 2'b11
    } tap_sel_t;

    typedef enum logic [1:0] {
        ACQ_IDLE   = 2'b00,
        ACQ_EXPOSE = 2'b01,
        ACQ_READ   = 2'b10
    } acq_state_t;

    typedef struct packed {
        logic [DIM_W-1:0]  cols;
        logic [DIM_W-1:0]  rows;
        logic [DIM_W-1:0]  col_start;
        logic [DIM_W-1:0]  row_start;
        tap_sel_t          taps;
        logic [EXPO_W-1:0] expo;
    } roi_cfg_t;

    typedef struct packed {
        logic             fval;
        logic             lval;
        logic             dval;
        logic [PIX_W-1:0] pix;
    } sens_px_t;

    typedef struct packed {
        logic                     fval;
        logic                     lval;
        logic                     dval;
        logic [LANE_W-1:0]        lanes;
        logic [TAP_MAX*PIX_W-1:0] data;
    } link_out_t;

    function automatic logic [LANE_W-1:0] tap_count(input tap_sel_t t);
        case (t)
            TAP_2:   tap_count = 4'h2;
            TAP_4:   tap_count = 4'h4;
            TAP_8:   tap_count = 4'h8;
            default: tap_count = 4'hA;
        endcase
    endfunction : tap_count

endpackage : roi_crop_pkg

// [core/stable_sync.sv]
`timescale 1ns/1ps
module stable_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.q = st_reg.s3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.q;
endmodule : stable_sync

// [core/image_roi_window_crop.sv]
`timescale 1ns/1ps
module image_roi_window_crop
    import roi_crop_pkg::*;
#(
    parameter logic [DIM_W-1:0] SENSOR_COLS = 16'h2560,
    parameter logic [DIM_W-1:0] SENSOR_ROWS = 16'h18EC
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WB_AW-1:0] wb_adr_i,
    input  wire logic [WB_DW-1:0] wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic      [WB_DW-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             link_clk_i,
    input  wire logic             link_rst_i,
    input  wire logic             trig_i,
    input  sens_px_t              sens_i,
    output logic                  readout_start_o,
    output link_out_t             link_o
);
    localparam logic [DIM_W-1:0] IMG_COLS_LIMIT = SENSOR_COLS;
    localparam logic [DIM_W-1:0] IMG_ROWS_LIMIT = SENSOR_ROWS;

    typedef struct packed {
        roi_cfg_t         eff;
        roi_cfg_t         xfer;
        logic             req_tgl;
        logic             dirty;
        logic             reject;
        logic             ack;
        logic [WB_DW-1:0] rdata;
    } sys_state_t;

    typedef struct packed {
        logic                     req_seen;
        logic                     ack_tgl;
        roi_cfg_t                 pend;
        logic                     pend_new;
        roi_cfg_t                 act;
        acq_state_t               acq;
        logic [EXPO_W-1:0]        expo_cnt;
        logic                     start;
        logic                     trig_d;
        logic                     fval_d;
        logic                     lval_d;
        logic [DIM_W-1:0]         col;
        logic [DIM_W-1:0]         row;
        logic [LANE_W-1:0]        fill;
        logic [TAP_MAX*PIX_W-1:0] pack;
        link_out_t                out;
    } link_state_t;

    sys_state_t  s_reg;
    sys_state_t  s_next;
    link_state_t l_reg;
    link_state_t l_next;
    logic        req_sync;
    logic        ack_sync;
    logic        trig_sync;

    function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] old_v,
                                               input logic [WB_DW-1:0] new_v,
                                               input logic [3:0]       sel);
        logic [WB_DW-1:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic cfg_ok(input roi_cfg_t c);
        logic ok;
        ok = ((c.cols & COLS_ALIGN_MASK) == '0);
        ok = ok && ((c.rows & ROWS_ALIGN_MASK) == '0);
        ok = ok && (c.cols >= COLS_MIN) && (c.rows >= ROWS_MIN);
        // column bound, checked by hardware too
        ok = ok && ({1'b0, c.cols} + {1'b0, c.col_start} <= {1'b0, IMG_COLS_LIMIT});
        // row bound, checked by hardware too
        ok = ok && ({1'b0, c.rows} + {1'b0, c.row_start} <= {1'b0, IMG_ROWS_LIMIT});
        return ok;
    endfunction : cfg_ok

    stable_sync #(.W(1)) u_ack_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (l_reg.ack_tgl),
        .q_o   (ack_sync)
    );

    stable_sync #(.W(1)) u_req_sync (
        .clk_i (link_clk_i),
        .rst_i (link_rst_i),
        .d_i   (s_reg.req_tgl),
        .q_o   (req_sync)
    );

    stable_sync #(.W(1)) u_trig_sync (
        .clk_i (link_clk_i),
        .rst_i (link_rst_i),
        .d_i   (trig_i),
        .q_o   (trig_sync)
    );

    // register side, system clock
    always_comb begin
        roi_cfg_t         cand;
        logic [WB_DW-1:0] wv;
        logic             busy;
        logic             touch;
        s_next = s_reg;
        cand   = s_reg.eff;
        wv     = '0;
        busy   = (s_reg.req_tgl != ack_sync);
        touch  = 1'b0;
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
        if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
            s_next.rdata = '0;
            case (wb_adr_i)
                ADR_ROI_COLS:       s_next.rdata[DIM_W-1:0] = s_reg.eff.cols;
                ADR_ROI_ROWS:       s_next.rdata[DIM_W-1:0] = s_reg.eff.rows;
                ADR_COL_START:      s_next.rdata[DIM_W-1:0] = s_reg.eff.col_start;
                ADR_ROW_START:      s_next.rdata[DIM_W-1:0] = s_reg.eff.row_start;
                ADR_TAP_SEL:        s_next.rdata[1:0]       = s_reg.eff.taps;
                ADR_EXPO_CYCLES:    s_next.rdata            = s_reg.eff.expo;
                ADR_STATUS: begin
                    s_next.rdata[STAT_REJECT] = s_reg.reject;
                    s_next.rdata[STAT_BUSY]   = busy || s_reg.dirty;
                end
                ADR_SENSOR_COLS:    s_next.rdata[DIM_W-1:0] = SENSOR_COLS;
                ADR_SENSOR_ROWS:    s_next.rdata[DIM_W-1:0] = SENSOR_ROWS;
                ADR_IMG_COLS_LIMIT: s_next.rdata[DIM_W-1:0] = IMG_COLS_LIMIT;
                ADR_IMG_ROWS_LIMIT: s_next.rdata[DIM_W-1:0] = IMG_ROWS_LIMIT;
                default:            s_next.rdata = '0;
            endcase
            if (wb_we_i) begin
                touch = 1'b1;
                case (wb_adr_i)
                    ADR_ROI_COLS: begin
                        wv = merge({16'h0000, cand.cols}, wb_dat_i, wb_sel_i);
                        cand.cols = wv[DIM_W-1:0];
                    end
                    ADR_ROI_ROWS: begin
                        wv = merge({16'h0000, cand.rows}, wb_dat_i, wb_sel_i);
                        cand.rows = wv[DIM_W-1:0];
                    end
                    ADR_COL_START: begin
                        wv = merge({16'h0000, cand.col_start}, wb_dat_i, wb_sel_i);
                        cand.col_start = wv[DIM_W-1:0];
                    end
                    ADR_ROW_START: begin
                        wv = merge({16'h0000, cand.row_start}, wb_dat_i, wb_sel_i);
                        cand.row_start = wv[DIM_W-1:0];
                    end
                    ADR_TAP_SEL: begin
                        wv = merge({30'h0000_0000, cand.taps}, wb_dat_i, wb_sel_i);
                        cand.taps = tap_sel_t'(wv[1:0]);
                    end
                    ADR_EXPO_CYCLES: begin
                        cand.expo = merge(cand.expo, wb_dat_i, wb_sel_i);
                    end
                    default: touch = 1'b0;
                endcase
            end
        end
        if (touch) begin
            if (cfg_ok(cand)) begin
                s_next.eff    = cand;
                s_next.reject = 1'b0;
                s_next.dirty  = 1'b1;
            end else begin
                s_next.reject = 1'b1;
            end
        end
        // word crossing: bundle held still while a handshake is open
        if (!busy && s_reg.dirty && !touch) begin
            s_next.xfer    = s_reg.eff;
            s_next.req_tgl = !s_reg.req_tgl;
            s_next.dirty   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg               <= '0;
            s_reg.eff.cols      <= IMG_COLS_LIMIT;
            s_reg.eff.rows      <= IMG_ROWS_LIMIT;
            s_reg.eff.col_start <= ORIGIN;
            s_reg.eff.row_start <= ORIGIN;
            s_reg.eff.taps      <= TAP_10;
            s_reg.eff.expo      <= EXPO_RESET;
            s_reg.dirty         <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdata;

    // link side, pixel clock
    always_comb begin
        logic             in_win;
        logic             last_col;
        logic [DIM_W:0]   col_end;
        logic [DIM_W:0]   row_end;
        logic [LANE_W-1:0] taps_n;
        l_next        = l_reg;
        l_next.start  = 1'b0;
        l_next.trig_d = trig_sync;
        l_next.fval_d = sens_i.fval;
        l_next.lval_d = sens_i.lval;
        l_next.out.dval = 1'b0;
        col_end = {1'b0, l_reg.act.col_start} + {1'b0, l_reg.act.cols};
        row_end = {1'b0, l_reg.act.row_start} + {1'b0, l_reg.act.rows};
        taps_n  = tap_count(l_reg.act.taps);
        case (l_reg.acq)
            ACQ_IDLE: begin
                if (trig_sync && !l_reg.trig_d) begin
                    // window changes only between frames
                    if (l_reg.pend_new) begin
                        l_next.act      = l_reg.pend;
                        l_next.pend_new = 1'b0;
                    end
                    l_next.expo_cnt = l_reg.pend_new ? l_reg.pend.expo : l_reg.act.expo;
                    l_next.acq      = ACQ_EXPOSE;
                end
            end
            // triggers ignored until exposure and readout end
            ACQ_EXPOSE: begin
                if (l_reg.expo_cnt <= EXPO_W'(1)) begin
                    l_next.start = 1'b1;
                    l_next.acq   = ACQ_READ;
                end else begin
                    l_next.expo_cnt = l_reg.expo_cnt - EXPO_W'(1);
                end
            end
            ACQ_READ: begin
                if (l_reg.fval_d && !sens_i.fval) begin
                    l_next.acq = ACQ_IDLE;
                end
            end
            default: l_next.acq = ACQ_IDLE;
        endcase
        // after the trigger take-over, so a bundle landing that cycle is not lost
        if (req_sync != l_reg.req_seen) begin
            l_next.req_seen = req_sync;
            l_next.pend     = s_reg.xfer;
            l_next.pend_new = 1'b1;
            l_next.ack_tgl  = !l_reg.ack_tgl;
        end
        if (sens_i.fval && !l_reg.fval_d) begin
            l_next.row = ORIGIN;
            l_next.col = ORIGIN;
        end else if (l_reg.lval_d && !sens_i.lval) begin
            l_next.row = l_reg.row + DIM_W'(1);
            l_next.col = ORIGIN;
        end
        in_win   = ({1'b0, l_reg.col} >= {1'b0, l_reg.act.col_start}) &&
                   ({1'b0, l_reg.col} < col_end) &&
                   ({1'b0, l_reg.row} >= {1'b0, l_reg.act.row_start}) &&
                   ({1'b0, l_reg.row} < row_end);
        last_col = ({1'b0, l_reg.col} == col_end - (DIM_W+1)'(1));
        l_next.out.fval = sens_i.fval && (l_reg.acq == ACQ_READ);
        l_next.out.lval = sens_i.fval && sens_i.lval && (l_reg.acq == ACQ_READ) &&
                          ({1'b0, l_reg.row} >= {1'b0, l_reg.act.row_start}) &&
                          ({1'b0, l_reg.row} < row_end);
        if (sens_i.fval && sens_i.lval && sens_i.dval) begin
            l_next.col = l_reg.col + DIM_W'(1);
            if (in_win && (l_reg.acq == ACQ_READ)) begin
                l_next.pack[l_reg.fill*PIX_W +: PIX_W] = sens_i.pix;
                if ((l_reg.fill + LANE_W'(1) == taps_n) || last_col) begin
                    // more lanes, fewer words per line
                    l_next.out.dval  = 1'b1;
                    l_next.out.lanes = l_reg.fill + LANE_W'(1);
                    l_next.out.data  = l_next.pack;
                    l_next.fill      = '0;
                    l_next.pack      = '0;
                end else begin
                    l_next.fill = l_reg.fill + LANE_W'(1);
                end
            end
        end
    end

    // registered output, at most one word per cycle, no stall
    always_ff @(posedge link_clk_i) begin
        if (link_rst_i) begin
            l_reg               <= '0;
            l_reg.act.cols      <= IMG_COLS_LIMIT;
            l_reg.act.rows      <= IMG_ROWS_LIMIT;
            l_reg.act.col_start <= ORIGIN;
            l_reg.act.row_start <= ORIGIN;
            l_reg.act.taps      <= TAP_10;
            l_reg.act.expo      <= EXPO_RESET;
            l_reg.acq           <= ACQ_IDLE;
        end else begin
            l_reg <= l_next;
        end
    end

    assign readout_start_o = l_reg.start;
    assign link_o          = l_reg.out;
endmodule : image_roi_window_crop

// [verification/image_roi_window_crop_properties.sv]
`timescale 1ns/1ps
module roi_crop_checker
    import roi_crop_pkg::*;
#(
    parameter logic [DIM_W-1:0] SENSOR_COLS = 16'h0080,
    parameter logic [DIM_W-1:0] SENSOR_ROWS = 16'h0010
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [WB_DW-1:0] wb_dat_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic             wb_we_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic [WB_DW-1:0] wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             link_clk_i,
    input wire logic             link_rst_i,
    input wire logic             trig_i,
    input wire sens_px_t         sens_i,
    input wire logic             readout_start_o,
    input wire link_out_t        link_o
);
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;

    ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("answer late");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("answer too long");
    ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("answer without request");
    sensor_cols_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_adr_i == ADR_SENSOR_COLS |-> wb_dat_o == {16'h0000, SENSOR_COLS})
        else $error("sensor width wrong");
    rows_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_adr_i == ADR_IMG_ROWS_LIMIT |-> wb_dat_o == {16'h0000, SENSOR_ROWS})
        else $error("row limit wrong");
    tap_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_ack && wb_adr_i == ADR_TAP_SEL |-> wb_dat_o[WB_DW-1:2] == '0)
        else $error("tap select upper bits set");
    readout_pulse_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        readout_start_o |=> !readout_start_o) else $error("readout pulse too long");
    readout_idle_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        readout_start_o |-> !link_o.fval) else $error("readout start inside frame");
    word_cause_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        link_o.dval |-> $past(sens_i.dval) && link_o.fval && link_o.lval)
        else $error("word without pixel");
    data_hold_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        !link_o.dval |-> $stable(link_o.data) && $stable(link_o.lanes))
        else $error("idle word changed");
    lanes_bound_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
        link_o.dval |-> link_o.lanes != '0 && link_o.lanes <= 4'hA)
        else $error("lane count out of range");

    cover property (@(posedge link_clk_i) readout_start_o);
    cover property (@(posedge link_clk_i) link_o.dval && link_o.lanes == 4'h4);
    cover property (@(posedge clk_i) rd_ack && wb_adr_i == ADR_STATUS);
endmodule : roi_crop_checker

bind image_roi_window_crop roi_crop_checker #(
    .SENSOR_COLS(SENSOR_COLS),
    .SENSOR_ROWS(SENSOR_ROWS)
) chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .link_clk_i, .link_rst_i, .trig_i, .sens_i, .readout_start_o,
    .link_o);

// [verification/frame_grabber_model.sv]
`timescale 1ns/1ps
module frame_grabber_model
    import roi_crop_pkg::*;
(
    input wire logic      link_clk_i,
    input wire link_out_t link_i
);
    logic [PIX_W-1:0] pix_q[$];
    int               words = 0;

    always @(posedge link_clk_i) begin
        if (link_i.dval === 1'b1) begin
            words++;
            for (int k = 0; k < TAP_MAX; k++) begin
                if (k < link_i.lanes) begin
                    pix_q.push_back(link_i.data[k*PIX_W +: PIX_W]);
                end
            end
        end
    end
endmodule : frame_grabber_model

// [verification/image_roi_window_crop_tb.sv]
`timescale 1ns/1ps
module image_roi_window_crop_tb;
    import roi_crop_pkg::*;
    localparam logic [DIM_W-1:0] COLS = 16'h0080;
    localparam logic [DIM_W-1:0] ROWS = 16'h0010;
    localparam logic [WB_AW-1:0] RA [6] = '{ADR_ROI_COLS, ADR_ROI_ROWS, ADR_COL_START,
        ADR_ROW_START, ADR_TAP_SEL, ADR_EXPO_CYCLES};
    localparam logic [15:0] RV [6] = '{COLS, ROWS, 16'h0000, 16'h0000, 16'h0003, 16'h0001};
    localparam logic [WB_AW-1:0] CA [12] = '{ADR_COL_START, ADR_ROI_COLS, ADR_ROI_COLS,
        ADR_ROI_COLS, ADR_ROI_ROWS, ADR_ROI_ROWS, ADR_ROI_ROWS, ADR_COL_START,
        ADR_ROW_START, ADR_ROW_START, ADR_SENSOR_COLS, ADR_IMG_ROWS_LIMIT};
    localparam logic [15:0] CW [12] = '{16'h0010, 16'h0048, 16'h0030, 16'h0040, 16'h0006,
        16'h0000, 16'h0004, 16'h0040, 16'h000D, 16'h000C, 16'h0055, 16'h0003};
    localparam logic [15:0] CR [12] = '{16'h0000, 16'h0080, 16'h0080, 16'h0040, 16'h0010,
        16'h0010, 16'h0004, 16'h0040, 16'h0000, 16'h000C, 16'h0080, 16'h0010};
    localparam logic [11:0] CJ = 12'h137;
    localparam int TAPS [4] = '{2, 4, 8, 10};

    logic             clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic             link_clk_i, link_rst_i, trig_i, readout_start_o;
    logic [WB_AW-1:0] wb_adr_i;
    logic [WB_DW-1:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]       wb_sel_i;
    sens_px_t         sens_i;
    link_out_t        link_o;
    int               err_count = 0;
    int               cmp_count = 0;
    int               starts = 0;

    image_roi_window_crop #(.SENSOR_COLS(COLS), .SENSOR_ROWS(ROWS)) DUT (.clk_i, .rst_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
        .wb_ack_o, .link_clk_i, .link_rst_i, .trig_i, .sens_i, .readout_start_o, .link_o);
    frame_grabber_model grabber (.link_clk_i(link_clk_i), .link_i(link_o));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #1.3;
        forever #3 link_clk_i = ~link_clk_i;
    end
    always @(posedge link_clk_i) begin
        if (readout_start_o === 1'b1) starts++;
    end

    function automatic logic [7:0] pix_of(input int r, input int c);
        return 8'(r * 29 + c * 3);
    endfunction : pix_of

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check

    // classic cycle: hold everything until ack is sampled, release at that edge
    task automatic wb_xfer(input logic [WB_AW-1:0] a, input logic we, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i  <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n == 16) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wb_xfer

    // window is 64 x 4 at column 64, row 12: right and bottom edges
    task automatic run_frame(input logic [1:0] t, input int tc);
        int r, c, n, s0;
        wb_xfer(ADR_TAP_SEL, 1'b1, {30'h0, t});
        wb_xfer(ADR_EXPO_CYCLES, 1'b1, 32'h0000_001E);
        for (n = 0; n < 50; n++) begin
            wb_xfer(ADR_STATUS, 1'b0, 32'h0);
            if (rd[STAT_BUSY] === 1'b0) break;
        end
        if (n == 50) begin
            err_count++;
            tally_and_finish();
        end
        grabber.pix_q.delete();
        grabber.words = 0;
        s0 = starts;
        // second trigger edge lands inside the exposure and must be ignored
        repeat (2) begin
            @(posedge clk_i) trig_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            trig_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        for (n = 0; n < 100 && starts == s0; n++) @(posedge link_clk_i);
        if (n == 100) begin
            err_count++;
            tally_and_finish();
        end
        @(posedge link_clk_i) sens_i <= {1'b1, 1'b0, 1'b0, 8'hA5};
        for (r = 0; r < ROWS; r++) begin
            for (c = 0; c < COLS + 2; c++) begin
                @(posedge link_clk_i) sens_i <= {1'b1, c < COLS, c < COLS, pix_of(r, c)};
            end
        end
        @(posedge link_clk_i) sens_i <= '0;
        repeat (20) @(posedge link_clk_i);
        check(32'(starts - s0), 32'h1);
        check(32'(grabber.words), 32'(4 * ((64 + tc - 1) / tc)));
        check(32'(grabber.pix_q.size()), 32'(64 * 4));
        for (n = 0; n < 256 && n < grabber.pix_q.size(); n++) begin
            check({24'h0, grabber.pix_q[n]}, {24'h0, pix_of(12 + n / 64, 64 + n % 64)});
        end
    endtask : run_frame

    initial begin
        rst_i = 1'b1;
        link_rst_i = 1'b1;
        wb_adr_i = '0;
        wb_dat_i = '0;
        wb_sel_i = 4'hF;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        trig_i = 1'b0;
        sens_i = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge link_clk_i) link_rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wb_xfer(RA[i], 1'b0, 32'h0);
            check(rd, {16'h0, RV[i]});
        end
        for (int i = 0; i < 12; i++) begin
            wb_xfer(CA[i], 1'b1, {16'h0, CW[i]});
            wb_xfer(CA[i], 1'b0, 32'h0);
            check(rd, {16'h0, CR[i]});
            wb_xfer(ADR_STATUS, 1'b0, 32'h0);
            check({31'h0, rd[STAT_REJECT]}, {31'h0, CJ[i]});
        end
        wb_xfer(8'h3C, 1'b1, 32'hFFFF_FFFF);
        wb_xfer(ADR_STATUS, 1'b0, 32'h0);
        check({31'h0, rd[STAT_REJECT]}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            run_frame(2'(i), TAPS[i]);
        end
        tally_and_finish();
    end
endmodule : image_roi_window_crop_tb
